// >>> rtl/status_pkg.sv
/*
  constants, field layout and address decode for the processor status word.
  assumes a single 20 MHz clock domain and an AXI4-Lite master on the bus side.
*/
package status_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  localparam int HALF_CARRY_BIT = 8;
  localparam int PRIO_HI = 7;
  localparam int PRIO_LO = 5;
  localparam int REPEAT_BIT = 4;
  localparam int NEG_BIT = 3;
  localparam int OVF_BIT = 2;
  localparam int ZERO_BIT = 1;
  localparam int CARRY_BIT = 0;
  localparam logic [15:0] IMPL_MASK = 16'h01FF;
  localparam logic [2:0] PRIO_ALL_MASKED = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // true when a byte address selects the status word
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    addr_hit = (addr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]);
  endfunction

endpackage

// >>> rtl/core_link_if.sv
/*
  internal carrier between the bus slave, the flag calculator and the status core.
  assumes all three sit on aclk.
*/
`timescale 1ns/1ps
interface core_link_if;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] wr_mask;
  logic [15:0] rd_data;
  logic calc_half_carry;
  logic calc_neg;
  logic calc_ovf;
  logic calc_zero;
  logic calc_carry;

  modport bus_side (output wr_en, output wr_data, output wr_mask, input rd_data);
  modport flag_side (output calc_half_carry, output calc_neg, output calc_ovf,
    output calc_zero, output calc_carry);
  modport core_side (input wr_en, input wr_data, input wr_mask, output rd_data,
    input calc_half_carry, input calc_neg, input calc_ovf, input calc_zero,
    input calc_carry);
endinterface

// >>> rtl/flag_calc.sv
/*
  combinational flag calculator for an add or subtract of two operands.
  assumes operands are held stable for the cycle in which they are flagged valid.
*/
`timescale 1ns/1ps
module flag_calc (
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic op_sub,
  input wire logic op_carry_in,
  input wire logic op_byte,
  core_link_if.flag_side link
);

  // subtract is a plus not-b plus carry-in; carry then means no borrow
  wire logic [15:0] b_eff = op_sub ? ~op_b : op_b;
  wire logic [16:0] sum = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, op_carry_in};

  // carry out of bit k, recovered from the sum and the inputs of bit k+1
  function automatic logic carry_out(input int k);
    carry_out = sum[k+1] ^ op_a[k+1] ^ b_eff[k+1];
  endfunction

  wire logic msb_a = op_byte ? op_a[7] : op_a[15];
  wire logic msb_b = op_byte ? b_eff[7] : b_eff[15];
  wire logic msb_r = op_byte ? sum[7] : sum[15];

  assign link.calc_half_carry = op_byte ? carry_out(3) : carry_out(7);
  assign link.calc_neg = msb_r;
  assign link.calc_ovf = (msb_a == msb_b) && (msb_r != msb_a);
  assign link.calc_zero = op_byte ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
  assign link.calc_carry = op_byte ? carry_out(7) : sum[16];

endmodule

// >>> rtl/axi_status_slave.sv
/*
  AXI4-Lite slave for the single status word.
  assumes one write and one read outstanding at most; unmapped addresses give SLVERR.
*/
`timescale 1ns/1ps
module axi_status_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [status_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [status_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  core_link_if.bus_side link
);

  logic [status_pkg::ADDR_W-1:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0] w_strb;

  // address and data are both held once their readys have dropped
  wire logic write_go = !s_awready && !s_wready && !s_bvalid;
  wire logic write_hit = status_pkg::addr_hit(aw_addr);
  wire logic read_hit = status_pkg::addr_hit(s_araddr);

  assign link.wr_en = write_go && write_hit;
  assign link.wr_data = w_data;
  assign link.wr_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= status_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_data <= s_wdata[15:0];
        w_strb <= s_wstrb[1:0];
        s_wready <= 1'b0;
      end
      if (write_go)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= write_hit ? status_pkg::RESP_OKAY : status_pkg::RESP_SLVERR;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= status_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= read_hit ? {16'h0000, link.rd_data} : 32'h0000_0000;
      s_rresp <= read_hit ? status_pkg::RESP_OKAY : status_pkg::RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

endmodule

// >>> rtl/alu_status_core.sv
/*
  processor status word: arithmetic flags, repeat indicator and current priority field.
  assumes the execution datapath presents one operation per cycle on op_valid, and
  the interrupt controller supplies the nesting disable bit and the extra priority bit.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module alu_status_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [status_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [status_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic op_valid,
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic op_sub,
  input wire logic op_carry_in,
  input wire logic op_byte,
  input wire logic affect_half_carry,
  input wire logic affect_neg,
  input wire logic affect_ovf,
  input wire logic affect_zero,
  input wire logic zero_sticky,
  input wire logic affect_carry,
  input wire logic priority_load,
  input wire logic [2:0] priority_value,
  input wire logic repeat_loop_active,
  input wire logic nesting_disable,
  input wire logic priority_high_bit,
  output logic [15:0] alu_status_word,
  output logic [3:0] priority_level,
  output logic user_irq_blocked
);

  core_link_if link ();

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave and flag calculator

  axi_status_slave bus_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .link(link.bus_side)
  );

  flag_calc calc (
    .op_a(op_a),
    .op_b(op_b),
    .op_sub(op_sub),
    .op_carry_in(op_carry_in),
    .op_byte(op_byte),
    .link(link.flag_side)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next-state selection

  wire logic [15:0] sw_bits = link.wr_en ? link.wr_mask : 16'h0000;
  wire logic hw_dc = op_valid && affect_half_carry;
  wire logic hw_n = op_valid && affect_neg;
  wire logic hw_ov = op_valid && affect_ovf;
  wire logic hw_z = op_valid && affect_zero;
  wire logic hw_c = op_valid && affect_carry;
  wire logic sw_ipl = sw_bits[status_pkg::PRIO_LO] && !nesting_disable;

  // hardware update first, then a software write, otherwise the bit holds
  function automatic logic pick_bit(input logic hw, input logic hw_val, input logic sw,
    input logic sw_val, input logic hold);
    pick_bit = hw ? hw_val : (sw ? sw_val : hold);
  endfunction

  // hardware terms are tested first so they win over a same-cycle write
  wire logic next_dc = pick_bit(hw_dc, link.calc_half_carry,
    sw_bits[status_pkg::HALF_CARRY_BIT], link.wr_data[status_pkg::HALF_CARRY_BIT],
    alu_status_word[status_pkg::HALF_CARRY_BIT]);
  wire logic next_n = pick_bit(hw_n, link.calc_neg,
    sw_bits[status_pkg::NEG_BIT], link.wr_data[status_pkg::NEG_BIT],
    alu_status_word[status_pkg::NEG_BIT]);
  wire logic next_ov = pick_bit(hw_ov, link.calc_ovf,
    sw_bits[status_pkg::OVF_BIT], link.wr_data[status_pkg::OVF_BIT],
    alu_status_word[status_pkg::OVF_BIT]);
  // sticky form keeps a set flag on a zero result; any non-zero result clears
  wire logic hw_zero_val = zero_sticky ?
    (link.calc_zero && alu_status_word[status_pkg::ZERO_BIT]) : link.calc_zero;
  wire logic next_z = pick_bit(hw_z, hw_zero_val,
    sw_bits[status_pkg::ZERO_BIT], link.wr_data[status_pkg::ZERO_BIT],
    alu_status_word[status_pkg::ZERO_BIT]);
  wire logic next_c = pick_bit(hw_c, link.calc_carry,
    sw_bits[status_pkg::CARRY_BIT], link.wr_data[status_pkg::CARRY_BIT],
    alu_status_word[status_pkg::CARRY_BIT]);
  wire logic [2:0] next_ipl = priority_load ? priority_value :
    sw_ipl ? link.wr_data[status_pkg::PRIO_HI:status_pkg::PRIO_LO] :
    alu_status_word[status_pkg::PRIO_HI:status_pkg::PRIO_LO];

  // repeat bit follows hardware only; upper bits are never stored
  wire logic [15:0] next_status = {7'h00, next_dc, next_ipl, repeat_loop_active,
    next_n, next_ov, next_z, next_c};

  assign link.rd_data = alu_status_word;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  // each output register has its own short process
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alu_status_word <= status_pkg::STATUS_RESET;
    else
      alu_status_word <= next_status;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      priority_level <= 4'h0;
    else
      priority_level <= {priority_high_bit, next_ipl};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      user_irq_blocked <= 1'b0;
    else
      user_irq_blocked <= (next_ipl == status_pkg::PRIO_ALL_MASKED);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_sw_ipl_blocked;
    link.wr_en && link.wr_mask[status_pkg::PRIO_LO] && nesting_disable && !priority_load;
  endsequence

  sequence seq_zero_op;
    op_valid && affect_zero && link.calc_zero && !zero_sticky;
  endsequence

  sequence seq_nonzero_op;
    op_valid && affect_zero && !link.calc_zero;
  endsequence

  half_carry_a: assert property (hw_dc |=>
    alu_status_word[8] == $past(link.calc_half_carry))
    else $error("half carry flag wrong");

  prio_field_a: assert property (priority_load |=> alu_status_word[7:5] == $past(priority_value))
    else $error("priority field not loaded");

  irq_block_a: assert property (user_irq_blocked == (alu_status_word[7:5] == 3'h7))
    else $error("user interrupt block mismatch");

  nest_protect_a: assert property (seq_sw_ipl_blocked |=> $stable(alu_status_word[7:5]))
    else $error("priority field written while protected");

  level_join_a: assert property (##1 priority_level ==
    {$past(priority_high_bit), alu_status_word[7:5]})
    else $error("priority level join wrong");

  repeat_bit_a: assert property (##1 alu_status_word[4] == $past(repeat_loop_active))
    else $error("repeat indicator does not follow loop");

  neg_flag_a: assert property (hw_n |=> alu_status_word[3] == $past(link.calc_neg))
    else $error("negative flag wrong");

  ovf_flag_a: assert property (hw_ov |=> alu_status_word[2] == $past(link.calc_ovf))
    else $error("overflow flag wrong");

  zero_set_a: assert property (seq_zero_op |=> alu_status_word[1])
    else $error("zero flag not set by zero result");

  zero_clear_a: assert property (seq_nonzero_op |=> !alu_status_word[1])
    else $error("zero flag not cleared by non-zero result");

  carry_flag_a: assert property (hw_c |=> alu_status_word[0] == $past(link.calc_carry))
    else $error("carry flag wrong");

  unimpl_zero_a: assert property (alu_status_word[15:9] == 7'h00)
    else $error("unimplemented bits not zero");

  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> alu_status_word == 16'h0000)
    else $error("status word not cleared by reset");

  hw_wins_a: assert property (hw_c && link.wr_en && link.wr_mask[0] |=>
    alu_status_word[0] == $past(link.calc_carry))
    else $error("software write beat hardware update");

  flags_hold_a: assert property (!op_valid && !link.wr_en |=>
    $stable(alu_status_word[3:0]) && $stable(alu_status_word[8]))
    else $error("flag changed with no cause");

  ////////////////////////////////////////////////////////////////////////////////
  // software writes, holds and bus answers

  sequence seq_sw_ipl_open;
    link.wr_en && link.wr_mask[status_pkg::PRIO_LO] && !nesting_disable && !priority_load;
  endsequence

  sequence seq_sticky_zero_op;
    op_valid && affect_zero && zero_sticky && link.calc_zero;
  endsequence

  sequence seq_read_hit;
    s_arvalid && s_arready && status_pkg::addr_hit(s_araddr);
  endsequence

  sequence seq_read_miss;
    s_arvalid && s_arready && !status_pkg::addr_hit(s_araddr);
  endsequence

  sw_prio_a: assert property (seq_sw_ipl_open |=>
    alu_status_word[7:5] == $past(link.wr_data[7:5]))
    else $error("priority field write lost");

  prio_hold_a: assert property (!priority_load && !link.wr_en |=>
    $stable(alu_status_word[7:5]))
    else $error("priority field changed with no cause");

  sticky_hold_a: assert property (seq_sticky_zero_op |=>
    $stable(alu_status_word[1]))
    else $error("sticky zero flag changed on zero result");

  sw_repeat_a: assert property (link.wr_en && link.wr_mask[4] |=>
    alu_status_word[4] == $past(repeat_loop_active))
    else $error("repeat indicator took a software write");

  sw_half_a: assert property (link.wr_en && link.wr_mask[8] && !hw_dc |=>
    alu_status_word[8] == $past(link.wr_data[8]))
    else $error("half carry flag write lost");

  sw_neg_a: assert property (link.wr_en && link.wr_mask[3] && !hw_n |=>
    alu_status_word[3] == $past(link.wr_data[3]))
    else $error("negative flag write lost");

  sw_ovf_a: assert property (link.wr_en && link.wr_mask[2] && !hw_ov |=>
    alu_status_word[2] == $past(link.wr_data[2]))
    else $error("overflow flag write lost");

  sw_zero_a: assert property (link.wr_en && link.wr_mask[1] && !hw_z |=>
    alu_status_word[1] == $past(link.wr_data[1]))
    else $error("zero flag write lost");

  sw_carry_a: assert property (link.wr_en && link.wr_mask[0] && !hw_c |=>
    alu_status_word[0] == $past(link.wr_data[0]))
    else $error("carry flag write lost");

  write_resp_a: assert property (link.wr_en |=> s_bvalid && s_bresp == status_pkg::RESP_OKAY)
    else $error("write answer missing");

  bvalid_once_a: assert property (s_bvalid && s_bready |=> !s_bvalid)
    else $error("write answer repeated");

  rvalid_once_a: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read answer repeated");

  write_ready_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("new write taken before answer");

  read_ready_a: assert property (s_rvalid |-> !s_arready)
    else $error("new read taken before answer");

  read_hit_a: assert property (seq_read_hit |=> s_rvalid &&
    s_rdata == {16'h0000, $past(alu_status_word)} && s_rresp == status_pkg::RESP_OKAY)
    else $error("read data not the status word");

  read_miss_a: assert property (seq_read_miss |=> s_rvalid &&
    s_rdata == 32'h0000_0000 && s_rresp == status_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");

endmodule

// >>> sim/exec_unit_model.sv
/*
  execution-side model: drives operations, priority loads and core control bits.
  assumes the status core samples every input on the rising edge of aclk.
*/
`timescale 1ns/1ps
module exec_unit_model (
  input wire logic aclk,
  output logic op_valid,
  output logic [15:0] op_a,
  output logic [15:0] op_b,
  output logic op_sub,
  output logic op_carry_in,
  output logic op_byte,
  output logic [4:0] affect,
  output logic zero_sticky,
  output logic priority_load,
  output logic [2:0] priority_value,
  output logic repeat_loop_active,
  output logic nesting_disable,
  output logic priority_high_bit
);
  initial
  begin
    {op_valid, op_a, op_b, op_sub, op_carry_in, op_byte, affect} = '0;
    {zero_sticky, priority_load, priority_value} = '0;
    {repeat_loop_active, nesting_disable, priority_high_bit} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one operation held for n edges; c is {a, b, sub, carry_in, byte}
  task automatic op(input logic [34:0] c, input logic [4:0] aff, input logic st, input int n);
    @(posedge aclk);
    {op_a, op_b, op_sub, op_carry_in, op_byte} <= c;
    {op_valid, affect, zero_sticky} <= {1'b1, aff, st};
    repeat (n) @(posedge aclk);
    // released operands change so stale values are never mistaken for live ones
    {op_valid, affect, op_a, op_b} <= {1'b0, 5'h00, ~c[34:19], ~c[18:3]};
  endtask

  task automatic prio(input logic [2:0] v);
    @(posedge aclk);
    {priority_load, priority_value} <= {1'b1, v};
    @(posedge aclk);
    {priority_load, priority_value} <= {1'b0, ~v};
  endtask

  task automatic ctl(input logic nd, input logic hb, input logic rp);
    @(posedge aclk);
    {nesting_disable, priority_high_bit, repeat_loop_active} <= {nd, hb, rp};
  endtask
endmodule

// >>> sim/tb_alu_status_core.sv
/*
  self-checking bench for the status word: bus accesses, flag updates, priority.
  assumes exec_unit_model drives the datapath side and a 20 MHz aclk.
*/
`timescale 1ns/1ps
module tb_alu_status_core;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, user_irq_blocked;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb, priority_level;
  logic [1:0] s_bresp, s_rresp, rs;
  logic [15:0] alu_status_word, op_a, op_b;
  logic op_valid, op_sub, op_carry_in, op_byte, zero_sticky, priority_load;
  logic repeat_loop_active, nesting_disable, priority_high_bit;
  logic [2:0] priority_value;
  logic [4:0] affect;
  int fail_count, n_compared;
  logic [34:0] ops [7] = '{{16'h7FFF, 16'h0001, 3'h0}, {16'hFFFF, 16'h0001, 3'h0},
    {16'h0005, 16'h0005, 3'h6}, {16'h0003, 16'h0005, 3'h6}, {16'h000F, 16'h0001, 3'h1},
    {16'h0080, 16'h0001, 3'h7}, {16'h12FF, 16'h0001, 3'h1}};

  alu_status_core i_alu_status_core (.*, .affect_half_carry(affect[4]),
    .affect_neg(affect[3]), .affect_ovf(affect[2]), .affect_zero(affect[1]),
    .affect_carry(affect[0]));
  exec_unit_model i_exec_unit_model (.*);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // {half carry, negative, overflow, zero, carry} worked out from the operands
  function automatic logic [4:0] flags(input logic [34:0] c);
    logic [15:0] a, b;
    logic [16:0] s;
    logic [8:0] lo;
    logic [4:0] h;
    a = c[34:19];
    b = c[2] ? ~c[18:3] : c[18:3];
    s = a + b + c[1];
    lo = a[7:0] + b[7:0] + c[1];
    h = a[3:0] + b[3:0] + c[1];
    if (c[0])
      flags = {h[4], lo[7], (a[7] == b[7]) && (lo[7] != a[7]), lo[7:0] == 8'h00, lo[8]};
    else
      flags = {lo[8], s[15], (a[15] == b[15]) && (s[15] != a[15]), s[15:0] == 16'h0000, s[16]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wchk(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    {s_awaddr, s_wdata, s_wstrb, s_awvalid, s_wvalid} <= {a, 16'h0000, d, 4'h3, 2'h3};
    fork
      begin
        do @(posedge aclk); while (!s_awready);
        s_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_wready);
        s_wvalid <= 1'b0;
      end
    join
    s_bready <= 1'b1;
    do @(posedge aclk); while (!s_bvalid);
    rs = s_bresp;
    s_bready <= 1'b0;
    chk("bresp", rs, er);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    {s_araddr, s_arvalid} <= {a, 1'b1};
    do @(posedge aclk); while (!s_arready);
    {s_arvalid, s_rready} <= 2'h1;
    do @(posedge aclk); while (!s_rvalid);
    {rd, rs} = {s_rdata, s_rresp};
    s_rready <= 1'b0;
    chk("rdata", rd, ed);
    chk("rresp", rs, er);
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #250000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h0000_0000, status_pkg::RESP_OKAY);
    wchk(8'h00, 16'hFFFF, status_pkg::RESP_OKAY);
    rchk(8'h00, 32'h0000_01EF, status_pkg::RESP_OKAY);
    chk("blocked", user_irq_blocked, 32'h1);
    chk("level", priority_level, 32'h7);
    wchk(8'h04, 16'h0000, status_pkg::RESP_SLVERR);
    rchk(8'h04, 32'h0000_0000, status_pkg::RESP_SLVERR);
    i_exec_unit_model.ctl(1'b1, 1'b1, 1'b0);
    wchk(8'h00, 16'h0000, status_pkg::RESP_OKAY);
    rchk(8'h00, 32'h0000_00E0, status_pkg::RESP_OKAY);
    chk("level", priority_level, 32'hF);
    i_exec_unit_model.ctl(1'b0, 1'b1, 1'b1);
    for (int p = 0; p < 8; p++)
    begin
      i_exec_unit_model.prio(3'(p));
      @(negedge aclk);
      chk("field", alu_status_word[7:5], 32'(p));
      chk("blocked", user_irq_blocked, 32'(p == 7));
      chk("level", priority_level, 32'(8 + p));
      chk("repeat", alu_status_word[4], 32'h1);
    end
    i_exec_unit_model.ctl(1'b0, 1'b0, 1'b0);
    @(posedge aclk);
    @(negedge aclk);
    chk("repeat", alu_status_word[4], 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      i_exec_unit_model.op(ops[i], 5'h1F, 1'b0, 1);
      @(negedge aclk);
      chk("flags", {alu_status_word[8], alu_status_word[3:0]}, flags(ops[i]));
    end
    i_exec_unit_model.op(ops[1], 5'h1F, 1'b0, 1);
    i_exec_unit_model.op(ops[1], 5'h02, 1'b1, 1);
    @(negedge aclk);
    chk("zero", alu_status_word[1], 32'h1);
    chk("others", {alu_status_word[8], alu_status_word[3:2], alu_status_word[0]}, 32'h9);
    i_exec_unit_model.op(ops[0], 5'h02, 1'b1, 1);
    @(negedge aclk);
    chk("zero", alu_status_word[1], 32'h0);
    i_exec_unit_model.op(ops[1], 5'h02, 1'b1, 1);
    @(negedge aclk);
    chk("zero", alu_status_word[1], 32'h0);
    fork
      wchk(8'h00, 16'h000F, status_pkg::RESP_OKAY);
      i_exec_unit_model.op(ops[0], 5'h01, 1'b0, 4);
    join
    rchk(8'h00, 32'h0000_000E, status_pkg::RESP_OKAY);
    finish_test();
  end
endmodule
